// file: bench/gie_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module gie_cpu_model (
  input  wire logic       clk_sys,
  output var  logic       cpuIntAck,
  output var  logic [3:0] cpuIntGroup,
  output var  logic       cpuTrapReq,
  output var  logic [4:0] cpuTrapNum
);
  initial begin
    cpuIntAck = 1'b0;
    cpuIntGroup = 4'h0;
    cpuTrapReq = 1'b0;
    cpuTrapNum = 5'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one request held for its taking edge; the answer is read one edge later
  task automatic fetch(input logic trap, input logic [4:0] num);
    if (trap && num == 5'h00) begin
      return; // trap zero is never issued while expansion runs
    end
    @(posedge clk_sys);
    cpuTrapReq <= trap;
    cpuIntAck <= !trap;
    cpuTrapNum <= num;
    cpuIntGroup <= num[3:0];
    @(posedge clk_sys);
    cpuTrapReq <= 1'b0;
    cpuIntAck <= 1'b0;
    // stale qualifiers would hide a design that ignores the strobe
    cpuTrapNum <= ~num;
    cpuIntGroup <= ~num[3:0];
    @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

// file: bench/test_grouped_interrupt_expander.sv
`timescale 1ns/1ps
`default_nettype none

module test_grouped_interrupt_expander;
  import gie_pkg::*;
  logic        clk_sys      = 1'b0;
  logic        rst_n        = 1'b0;
  logic        wbCyc        = 1'b0;
  logic        wbStb        = 1'b0;
  logic        wbWe         = 1'b0;
  logic [15:0] wbAdr        = 16'h0000;
  logic [3:0]  wbSel        = 4'h3;
  logic [31:0] wbDatW       = 32'h0000_0000;
  logic [95:0] srcIrq       = 96'h0;
  logic        protWrUnlock = 1'b1;
  logic [31:0] wbDatR, vecAddr, rd;
  logic        wbAck, cpuIntAck, cpuTrapReq, vecValid, vecHit, irqOut;
  logic [3:0]  cpuIntGroup;
  logic [4:0]  cpuTrapNum;
  logic [11:0] cpuIrq;
  int          nErrors      = 0;
  int          checksDone   = 0;

  always #50 clk_sys = ~clk_sys;

  gie_expander uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .srcIrq(srcIrq), .protWrUnlock(protWrUnlock),
    .cpuIntAck(cpuIntAck), .cpuIntGroup(cpuIntGroup), .cpuTrapReq(cpuTrapReq),
    .cpuTrapNum(cpuTrapNum), .cpuIrq(cpuIrq), .vecValid(vecValid), .vecHit(vecHit),
    .vecAddr(vecAddr), .irqOut(irqOut)
  );
  gie_cpu_model cpu (
    .clk_sys(clk_sys), .cpuIntAck(cpuIntAck), .cpuIntGroup(cpuIntGroup),
    .cpuTrapReq(cpuTrapReq), .cpuTrapNum(cpuTrapNum)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [13:0] grpIdx(input int g, input int flag);
    return 14'(IDX_GRP_BASE + 2 * (g - 1) + flag);
  endfunction
  function automatic logic [13:0] vecIdx(input int g, input int p, input int hi);
    return 14'(IDX_VEC_BASE + VEC_GRP_BASE + ((g - 1) * 8 + p - 1) * 2 + hi);
  endfunction
  function automatic logic [31:0] vecVal(input int g, input int p);
    return {16'hC000, 8'(g), 8'(p)};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // the master waits for ack under a bound; a lost ack counts as a mismatch
  task automatic wb(input logic we, input logic [13:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbDatW <= {16'h0000, wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 16);
    chk("ack", 32'h1, {31'h0, wbAck});
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rdChk(input string what, input logic [13:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    chk(what, {16'h0000, exp}, rd);
  endtask

  task automatic vecChk(input string what, input logic trap, input logic [4:0] num,
                        input logic hit, input logic [31:0] adr);
    cpu.fetch(trap, num);
    chk(what, {30'h0, 1'b1, hit}, {30'h0, vecValid, vecHit});
    chk(what, adr, vecAddr);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(1'b1, IDX_MSK, 16'h0007);
    rdChk("ctrl", IDX_CTRL, 16'h0000);
    rdChk("ack", IDX_ACK, 16'h0000);
    rdChk("unmapped", 14'h0CFC, 16'h0000);
    for (int g = 1; g <= NGRP; g++) begin
      rdChk("enable", grpIdx(g, 0), 16'h0000);
      rdChk("flag", grpIdx(g, 1), 16'h0000);
      for (int p = 1; p <= NPOS; p++) begin
        wb(1'b1, vecIdx(g, p, 0), 16'(g * 256 + p));
        wb(1'b1, vecIdx(g, p, 1), 16'hC000);
      end
    end
    $display("test reset and table done");
    protWrUnlock <= 1'b0;
    wb(1'b1, vecIdx(1, 1, 0), 16'hFFFF);
    wb(1'b1, grpIdx(4, 0), 16'h00FF);
    protWrUnlock <= 1'b1;
    rdChk("locked vector", vecIdx(1, 1, 0), 16'h0101);
    rdChk("open enable", grpIdx(4, 0), 16'h00FF);
    chk("irq locked", 32'h1, {31'h0, irqOut});
    rdChk("status locked", IDX_STS, 16'h0004);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", 32'h0, {31'h0, irqOut});
    $display("test protection done");
    vecChk("trap off", 1'b1, 5'h01, 1'b0, 32'h0);
    wb(1'b1, IDX_CTRL, 16'h0001);
    for (int n = 1; n <= NGRP; n++) begin
      vecChk("trap", 1'b1, 5'(n), 1'b1, vecVal(n, 1));
    end
    vecChk("trap high", 1'b1, 5'h0D, 1'b0, 32'h0);
    rdChk("ctrl vector", IDX_CTRL, 16'h0DD1);
    $display("test traps done");
    for (int p = 1; p <= 6; p++) begin
      @(posedge clk_sys);
      srcIrq[CAP_GRP * 8 + p - 1] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("line four", 32'h1, {31'h0, cpuIrq[CAP_GRP]});
      rdChk("flag four", grpIdx(4, 1), 16'(1 << (p - 1)));
      vecChk("capture", 1'b0, 5'h04, 1'b1, vecVal(4, p));
      chk("line acked", 32'h0, {31'h0, cpuIrq[CAP_GRP]});
      srcIrq[CAP_GRP * 8 + p - 1] <= 1'b0;
      wb(1'b1, IDX_ACK, 16'h0008);
    end
    @(posedge clk_sys);
    srcIrq[31:30] <= 2'b11;
    repeat (2) @(posedge clk_sys);
    chk("reserved line", 32'h0, {31'h0, cpuIrq[CAP_GRP]});
    rdChk("reserved flag", grpIdx(4, 1), 16'h0000);
    srcIrq[31:30] <= 2'b00;
    $display("test capture group done");
    @(posedge clk_sys);
    srcIrq[SPARE_G1 * 8 + 7 : SPARE_G0 * 8] <= 16'hFFFF;
    repeat (2) @(posedge clk_sys);
    for (int g = 10; g <= 11; g++) begin
      rdChk("spare flag", grpIdx(g, 1), 16'h0000);
      wb(1'b1, grpIdx(g, 0), 16'h0080);
      wb(1'b1, grpIdx(g, 1), 16'h0080);
      @(posedge clk_sys);
      chk("soft line", 32'h1, {31'h0, cpuIrq[g - 1]});
      vecChk("soft vector", 1'b0, 5'(g), 1'b1, vecVal(g, 8));
    end
    $display("test spare groups done");
    vecChk("spurious", 1'b0, 5'h02, 1'b0, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("irq spurious", 32'h1, {31'h0, irqOut});
    rdChk("status spurious", IDX_STS, 16'h0002);
    wb(1'b1, IDX_MSK, 16'h0000);
    vecChk("masked", 1'b0, 5'h02, 1'b0, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irqOut});
    rdChk("status masked", IDX_STS, 16'h0002);
    $display("test status done");
    giveVerdict();
  end

  initial begin
    // the tests need about nine hundred cycles
    repeat (20000) @(posedge clk_sys);
    nErrors++;
    giveVerdict();
  end
endmodule

`default_nettype wire

// file: hdl/gie_expander.sv
// Summary of operation
// - eight positions merge into each of twelve cpu lines, addressed by group and position.
// - only fifty-eight positions have peripheral sources; the rest are reserved.
// - the vector table has no reset vector entry.
// - enabled trap N, one to twelve, fetches the vector of group N position one.
// - group four holds six capture interrupts at positions one to six.
// - an enabled reserved position works as software interrupt when software sets its flag.
// - groups ten and eleven have no peripheral sources at all.
// - each group has an enable and a flag register, plus control and acknowledge.
// - control registers need no unlock; vector table writes only while unlocked.
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module gie_expander
  import gie_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic [95:0] srcIrq,
  input  wire logic        protWrUnlock,
  input  wire logic        cpuIntAck,
  input  wire logic [3:0]  cpuIntGroup,
  input  wire logic        cpuTrapReq,
  input  wire logic [4:0]  cpuTrapNum,
  output var  logic [11:0] cpuIrq,
  output var  logic        vecValid,
  output var  logic        vecHit,
  output var  logic [31:0] vecAddr,
  output var  logic        irqOut
);
  import gie_pkg::*;

  typedef struct packed {
    logic              ctrlEn;
    logic [14:0]       lastVec;
    logic [11:0]       ackBits;
    logic [95:0]       ier;
    logic [95:0]       ifr;
    logic [95:0]       srcPrev;
    logic [NSTS-1:0]   sts;
    logic [NSTS-1:0]   msk;
    logic              wbAck;
    logic [31:0]       wbDat;
    logic [11:0]       cpuIrq;
    logic              vecValid;
    logic              vecHit;
    logic [31:0]       vecAddr;
    logic              irqOut;
  } gie_state_t;

  gie_state_t q_r;
  gie_state_t q_nxt;
  logic [15:0] vecMem [VEC_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [15:0] wdat,
                                             input logic [3:0]  sel);
    mergeLanes = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
  endfunction

  // vector table word of group g, position p, both counted from zero
  function automatic logic [7:0] vecIdx(input logic [3:0] g, input logic [2:0] p);
    vecIdx = VEC_GRP_BASE + {g, p, 1'b0};
  endfunction

  // lowest pending position gives priority; bit 3 flags that one was found
  function automatic logic [3:0] lowestPos(input logic [7:0] pend);
    lowestPos = 4'h0;
    for (int i = NPOS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        lowestPos = {1'b1, 3'(i)};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic [13:0] idx;
  logic        busReq;
  logic        busWr;
  logic        inGrp;
  logic [13:0] grpOff;
  logic [3:0]  grpSel;
  logic        inVec;
  logic [7:0]  vecWordSel;
  logic        vecWrOk;
  logic [95:0] srcRise;
  logic [31:0] trapVecExp;
  logic [3:0]  trapGrp;
  logic        ifrWr;

  assign idx        = wb_adr_i[15:2];
  assign busReq     = wb_cyc_i && wb_stb_i && !q_r.wbAck;
  assign busWr      = busReq && wb_we_i;
  assign inGrp      = (idx >= IDX_GRP_BASE) && (idx <= IDX_GRP_LAST);
  assign grpOff     = idx - IDX_GRP_BASE;
  assign grpSel     = grpOff[4:1];
  assign inVec      = (idx >= IDX_VEC_BASE) && (idx <= IDX_VEC_LAST);
  assign vecWordSel = idx[7:0];
  assign vecWrOk    = busWr && inVec && protWrUnlock;
  // sources run on clk_sys; a rising level marks a new event
  assign srcRise    = srcIrq & ~q_r.srcPrev & WIRED_MASK;
  assign trapGrp    = 4'(cpuTrapNum - 5'd1);
  assign trapVecExp = {vecMem[8'(vecIdx(trapGrp, 3'd0) + 8'd1)], vecMem[vecIdx(trapGrp, 3'd0)]};
  assign ifrWr      = busWr && inGrp && grpOff[0];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0]  ackG;
    logic [3:0]  hit;
    logic [7:0]  vIdx;
    logic [NSTS-1:0] ev;
    ackG = 4'(cpuIntGroup - 4'd1);
    hit  = 4'h0;
    vIdx = 8'h00;
    ev   = '0;
    q_nxt = q_r;
    q_nxt.srcPrev  = srcIrq;
    q_nxt.wbAck    = busReq;
    q_nxt.vecValid = 1'b0;

    // register reads
    q_nxt.wbDat = RST_WORD;
    if (busReq && !wb_we_i) begin
      if (idx == IDX_CTRL) begin
        q_nxt.wbDat = {16'h0000, q_r.lastVec, q_r.ctrlEn};
      end else if (idx == IDX_ACK) begin
        q_nxt.wbDat = {20'h00000, q_r.ackBits};
      end else if (inGrp) begin
        q_nxt.wbDat = {24'h000000, grpOff[0] ? q_r.ifr[grpSel*8 +: 8] : q_r.ier[grpSel*8 +: 8]};
      end else if (idx == IDX_STS) begin
        q_nxt.wbDat = {29'h0, q_r.sts};
        q_nxt.sts   = '0;
      end else if (idx == IDX_MSK) begin
        q_nxt.wbDat = {29'h0, q_r.msk};
      end else if (inVec) begin
        q_nxt.wbDat = {16'h0000, vecMem[vecWordSel]};
      end
    end

    // register writes; no unlock needed here
    if (busWr) begin
      if (idx == IDX_CTRL) begin
        q_nxt.ctrlEn = wb_sel_i[0] ? wb_dat_i[CTRL_EN_BIT] : q_r.ctrlEn;
      end else if (idx == IDX_ACK) begin
        q_nxt.ackBits = q_r.ackBits & ~(wb_dat_i[11:0] & {{4{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
      end else if (inGrp && !grpOff[0]) begin
        q_nxt.ier[grpSel*8 +: 8] = 8'(mergeLanes({8'h00, q_r.ier[grpSel*8 +: 8]},
                                                 wb_dat_i[15:0], wb_sel_i));
      end else if (inGrp) begin
        // a whole-byte write can drop a peripheral flag raised just before it
        q_nxt.ifr[grpSel*8 +: 8] = 8'(mergeLanes({8'h00, q_r.ifr[grpSel*8 +: 8]},
                                                 wb_dat_i[15:0], wb_sel_i));
      end else if (idx == IDX_MSK) begin
        q_nxt.msk = wb_sel_i[0] ? wb_dat_i[NSTS-1:0] : q_r.msk;
      end else if (inVec && !protWrUnlock) begin
        ev[STS_PROT] = 1'b1;
      end
    end

    // cpu acknowledge wins over a trap in the same cycle while ctrlEn is set; with ctrlEn clear the trap is answered
    if (cpuIntAck && q_r.ctrlEn) begin
      q_nxt.vecValid = 1'b1;
      q_nxt.vecHit   = 1'b0;
      q_nxt.vecAddr  = RST_WORD;
      if ((cpuIntGroup >= 4'd1) && (cpuIntGroup <= 4'(NGRP))) begin
        hit = lowestPos(q_r.ifr[ackG*8 +: 8] & q_r.ier[ackG*8 +: 8]);
      end
      if (hit[3]) begin
        vIdx = vecIdx(ackG, hit[2:0]);
        q_nxt.ifr[{ackG, hit[2:0]}] = 1'b0;
        q_nxt.ackBits[ackG] = 1'b1;
        q_nxt.vecHit  = 1'b1;
        q_nxt.vecAddr = {vecMem[8'(vIdx + 8'd1)], vecMem[vIdx]};
        q_nxt.lastVec = 15'({6'h0D, vIdx} >> 1);
      end else begin
        ev[STS_SPUR] = 1'b1;
      end
    end else if (cpuTrapReq) begin
      q_nxt.vecValid = 1'b1;
      q_nxt.vecHit   = 1'b0;
      q_nxt.vecAddr  = RST_WORD;
      if (q_r.ctrlEn && (cpuTrapNum == 5'd0)) begin
        // no reset entry exists; flag it instead of jumping anywhere
        ev[STS_TRAP0] = 1'b1;
      end else if (q_r.ctrlEn && (cpuTrapNum <= 5'(NGRP))) begin
        q_nxt.vecHit  = 1'b1;
        q_nxt.vecAddr = trapVecExp;
        q_nxt.lastVec = 15'({6'h0D, vecIdx(trapGrp, 3'd0)} >> 1);
      end
    end

    // hardware sets win over any clear in the same cycle
    q_nxt.ifr = q_nxt.ifr | srcRise;
    q_nxt.sts = q_nxt.sts | ev;
    q_nxt.irqOut = |(q_nxt.sts & q_nxt.msk);

    for (int g = 0; g < NGRP; g++) begin
      q_nxt.cpuIrq[g] = q_nxt.ctrlEn && !q_nxt.ackBits[g]
                        && |(q_nxt.ifr[g*8 +: 8] & q_nxt.ier[g*8 +: 8]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
      q_r.ctrlEn <= RST_EN;
    end else begin
      q_r <= q_nxt;
    end
  end

  // table contents are undefined until software loads them
  always_ff @(posedge clk_sys) begin
    if (vecWrOk) begin
      vecMem[vecWordSel] <= mergeLanes(vecMem[vecWordSel], wb_dat_i[15:0], wb_sel_i);
    end
  end

  assign wb_dat_o = q_r.wbDat;
  assign wb_ack_o = q_r.wbAck;
  assign cpuIrq   = q_r.cpuIrq;
  assign vecValid = q_r.vecValid;
  assign vecHit   = q_r.vecHit;
  assign vecAddr  = q_r.vecAddr;
  assign irqOut   = q_r.irqOut;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence busReqS;
    wb_cyc_i && wb_stb_i && !q_r.wbAck;
  endsequence
  sequence answerS;
    q_r.wbAck ##1 !q_r.wbAck;
  endsequence
  sequence trapZeroS;
    cpuTrapReq && !cpuIntAck && q_r.ctrlEn && cpuTrapNum == 5'd0;
  endsequence
  sequence trapGrpS;
    cpuTrapReq && !cpuIntAck && q_r.ctrlEn && cpuTrapNum >= 5'd1 && cpuTrapNum <= 5'd12;
  endsequence
  sequence trapHighS;
    cpuTrapReq && !cpuIntAck && q_r.ctrlEn && cpuTrapNum > 5'd12;
  endsequence
  sequence capDeliverS;
    cpuIntAck && q_r.ctrlEn && cpuIntGroup == 4'(CAP_GRP + 1)
    && (q_r.ifr[CAP_GRP*8 +: 8] & q_r.ier[CAP_GRP*8 +: 8]) != 8'h00;
  endsequence

  busAnswer_a: assert property (busReqS |=> answerS)
    else $error("bus request not answered in one cycle");
  trapZero_a: assert property (trapZeroS |=> vecValid && !vecHit && q_r.sts[STS_TRAP0])
    else $error("trap zero not flagged");
  trapGroup_a: assert property (trapGrpS |=>
    vecValid && vecHit && vecAddr == $past(trapVecExp))
    else $error("trap vector not from first group entry");
  trapHigh_a: assert property (trapHighS |=> vecValid && !vecHit && vecAddr == 32'h0)
    else $error("trap above twelve fetched a vector");
  flagSet_a: assert property (srcRise != 96'h0 |=>
    (q_r.ifr & $past(srcRise)) == $past(srcRise))
    else $error("peripheral event lost");
  reservedRise_a: assert property (
    ((q_r.ifr & ~$past(q_r.ifr) & ~WIRED_MASK) != 96'h0) |-> $past(ifrWr))
    else $error("reserved flag set without software");
  spareGroups_a: assert property (
    (q_r.ifr[SPARE_G0*8 +: 16] & ~$past(q_r.ifr[SPARE_G0*8 +: 16])) != 16'h0 |-> $past(ifrWr))
    else $error("spare group flag set by hardware");
  capFlag_a: assert property (
    srcIrq[CAP_GRP*8] && !q_r.srcPrev[CAP_GRP*8] |=> q_r.ifr[CAP_GRP*8])
    else $error("capture unit one flag missed");
  capDeliver_a: assert property (capDeliverS |=>
    vecHit && q_r.ackBits[CAP_GRP] && !cpuIrq[CAP_GRP])
    else $error("delivered group not blocked by its ack bit");
  lineGate_a: assert property (
    (cpuIrq & q_r.ackBits) == 12'h0 && (cpuIrq == 12'h0 || q_r.ctrlEn))
    else $error("cpu line raised while blocked");
  lineUp_a: assert property (
    q_r.ctrlEn && !q_r.ackBits[CAP_GRP]
    && (q_r.ifr[CAP_GRP*8 +: 8] & q_r.ier[CAP_GRP*8 +: 8]) != 8'h00 |-> cpuIrq[CAP_GRP])
    else $error("pending enabled group line not raised");
  protect_a: assert property (
    busReqS and (wb_we_i && inVec && !protWrUnlock) |=> q_r.sts[STS_PROT] && wb_ack_o)
    else $error("locked vector write not refused");

endmodule

`default_nettype wire

// file: hdl/gie_pkg.sv
package gie_pkg;

  localparam int NGRP = 12;
  localparam int NPOS = 8;
  localparam int NSRC = 96;

  // register indexes; byte address is four times the index
  localparam logic [13:0] IDX_CTRL     = 14'h0CE0;
  localparam logic [13:0] IDX_ACK      = 14'h0CE1;
  localparam logic [13:0] IDX_GRP_BASE = 14'h0CE2;
  localparam logic [13:0] IDX_GRP_LAST = 14'h0CF9;
  localparam logic [13:0] IDX_STS      = 14'h0CFA;
  localparam logic [13:0] IDX_MSK      = 14'h0CFB;
  localparam logic [13:0] IDX_VEC_BASE = 14'h0D00;
  localparam logic [13:0] IDX_VEC_LAST = 14'h0DFF;

  localparam int VEC_WORDS = 256;
  localparam logic [7:0] VEC_GRP_BASE = 8'h20;

  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_VEC_LSB = 1;

  // event status bits
  localparam int NSTS      = 3;
  localparam int STS_TRAP0 = 0;
  localparam int STS_SPUR  = 1;
  localparam int STS_PROT  = 2;

  // positions wired to peripherals, group 1 in the low byte, position 1 in bit 0
  localparam logic [95:0] WIRED_MASK = 96'hDF00_00FF_333F_3F03_3F3F_3FFB;

  localparam int CAP_GRP  = 3;
  localparam int SPARE_G0 = 9;
  localparam int SPARE_G1 = 10;

  localparam logic        RST_EN    = 1'b0;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;

endpackage
